// ==== hw/cps_pkg.sv ====
package cps_pkg;

  localparam int REG_W = 9;
  localparam int INT_W = 3;
  localparam int CHS_N = 5;

  typedef logic [REG_W-1:0] cps_reg_type;

  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_SPD_STAT = 6'h31;
  localparam logic [5:0] IDX_PD1      = 6'h32;
  localparam logic [5:0] IDX_PD2      = 6'h33;
  localparam logic [5:0] IDX_RB       = 6'h34;
  localparam logic [5:0] IDX_RST      = 6'h35;
  localparam logic [5:0] IDX_INT_STAT = 6'h38;
  localparam logic [5:0] IDX_INT_EN   = 6'h39;
  localparam logic [5:0] IDX_INT_CLR  = 6'h3a;

  // Field positions
  localparam int PD1_CHIP     = 0;
  localparam int PD1_ADC      = 1;
  localparam int PD1_DAC_LO   = 2;
  localparam int PD1_ALL      = 6;
  localparam int PD2_OSC      = 0;
  localparam int PD2_PLLA     = 1;
  localparam int PD2_PLLB     = 2;
  localparam int PD2_CREC     = 3;
  localparam int PD2_TX       = 4;
  localparam int PD2_RX       = 5;
  localparam int RB_SEL_LO    = 0;
  localparam int RB_CONT      = 3;
  localparam int RB_EN        = 4;
  localparam int ST_PRE       = 3;
  localparam int ST_RATE_LO   = 4;
  localparam int ST_UNLOCK    = 6;
  localparam int EV_LOST      = 0;
  localparam int EV_GAIN      = 1;
  localparam int EV_RATE      = 2;

  // Reset values and writable masks
  localparam cps_reg_type PD1_RST  = 9'h07e;
  localparam cps_reg_type PD1_MASK = 9'h07f;
  localparam cps_reg_type PD2_RST  = 9'h03e;
  localparam cps_reg_type PD2_MASK = 9'h03f;
  localparam cps_reg_type RB_RST   = 9'h000;
  localparam cps_reg_type RB_MASK  = 9'h01f;
  localparam logic [INT_W-1:0] INT_EN_RST = 3'h0;

  // Read-back select codes
  localparam logic [2:0] SEL_ERR = 3'h0;
  localparam logic [2:0] SEL_CS1 = 3'h1;
  localparam logic [2:0] SEL_CS2 = 3'h2;
  localparam logic [2:0] SEL_CS3 = 3'h3;
  localparam logic [2:0] SEL_CS4 = 3'h4;
  localparam logic [2:0] SEL_CS5 = 3'h5;
  localparam logic [2:0] SEL_SPD = 3'h6;

endpackage

// ==== hw/cps_regs.sv ====
// Implementation choice: the Wishbone register port.
`timescale 1ns/1ps
// Summary of operation
// - Status bit 3 shows received pre-emphasis
// - Status bits 5:4 encode recovered rate
// - Status bit 6 high when not locked
// - Chip power-save bit mutes, stops digital
// - ADC off bit, defaults off
// - Four DAC off bits, default all off
// - Every-DAC bit overrides single DAC bits
// - Oscillator off bit, defaults on
// - PLL A and B off bits, default off
// - Clock recovery off bit, default off
// - Transmitter off bit, default off
// - Receiver off bit, default off
// - Three-bit select picks read-back source
// - Continuous read-back enable bit, default off
// - Read-back only while enable bit set
// - Any reset register write restores power-down and read-back defaults; interrupt enable and status keep their values
module cps_regs (
  // System
  input  wire  logic              clk_i,
  input  wire  logic              rst_i,
  // Wishbone slave
  input  wire  logic              wb_cyc_i,
  input  wire  logic              wb_stb_i,
  input  wire  logic              wb_we_i,
  input  wire  logic [7:0]        wb_adr_i,
  input  wire  logic [3:0]        wb_sel_i,
  input  wire  logic [31:0]       wb_dat_i,
  output logic       [31:0]       wb_dat_o,
  output logic                    wb_ack_o,
  // Receiver state, asynchronous
  input  wire  logic              rx_preemph_i,
  input  wire  logic [1:0]        rx_rate_i,
  input  wire  logic              rx_unlock_i,
  // Status sources, same clock
  input  wire  cps_pkg::cps_reg_type error_status_i,
  input  wire  logic [44:0]       chan_status_i,
  // Power controls
  output logic                    outputs_mute_o,
  output logic                    adc_off_o,
  output logic       [3:0]        dac_off_o,
  output logic                    oscillator_off_o,
  output logic                    pll_a_off_o,
  output logic                    pll_b_off_o,
  output logic                    clock_recovery_off_o,
  output logic                    spdif_transmitter_off_o,
  output logic                    spdif_receiver_off_o,
  // Read-back
  output cps_pkg::cps_reg_type    readback_data_o,
  output logic                    readback_valid_o,
  output logic                    readback_continuous_o,
  // Interrupt
  output logic                    irq_o
);
  import cps_pkg::*;

  ////////////////////////////////////////////////////////////
  // Helpers

  function automatic cps_reg_type merge_w(
    input cps_reg_type old_v,
    input logic [31:0] dat,
    input logic [3:0]  sel
  );
    cps_reg_type v;
    v = old_v;
    if (sel[0]) begin
      v[7:0] = dat[7:0];
    end
    if (sel[1]) begin
      v[8] = dat[8];
    end
    return v;
  endfunction

  function automatic cps_reg_type rb_mux(
    input logic [2:0]  sel,
    input cps_reg_type err,
    input logic [44:0] chs,
    input cps_reg_type spd
  );
    cps_reg_type v;
    v = '0;
    case (sel)
      SEL_ERR: v = err;
      SEL_CS1: v = chs[8:0];
      SEL_CS2: v = chs[17:9];
      SEL_CS3: v = chs[26:18];
      SEL_CS4: v = chs[35:27];
      SEL_CS5: v = chs[44:36];
      SEL_SPD: v = spd;
      default: v = '0;
    endcase
    return v;
  endfunction

  ////////////////////////////////////////////////////////////
  // Bus decode

  logic                ack_r;
  logic [5:0]          idx;
  logic                req;
  logic                wr_fire;
  logic                rd_take;
  cps_reg_type         pd1_r;
  cps_reg_type         pd2_r;
  cps_reg_type         rb_r;
  logic [INT_W-1:0]    int_en_r;
  logic [INT_W-1:0]    int_st_r;
  logic [INT_W-1:0]    int_st_nxt;
  logic [INT_W-1:0]    ev;
  logic [3:0]          rx_s1_r;
  logic [3:0]          rx_s2_r;
  logic [3:0]          rx_old_r;
  cps_reg_type         spd_stat;
  cps_reg_type         rb_sel_v;
  cps_reg_type         rd_v;
  cps_reg_type         clr_v;
  logic                soft_rst;
  logic                rb_load_r;
  logic [1:0]          up_r;

  assign idx      = wb_adr_i[7:2];
  assign req      = wb_cyc_i && wb_stb_i;
  // Writes land at the edge where the master sees ack
  assign wr_fire  = req && wb_we_i && ack_r;
  assign rd_take  = req && !wb_we_i && !ack_r;
  assign soft_rst = wr_fire && (idx == IDX_RST);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req && !ack_r;
    end
  end

  assign wb_ack_o = ack_r;

  ////////////////////////////////////////////////////////////
  // Receiver state synchroniser

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_s1_r  <= 4'h0;
      rx_s2_r  <= 4'h0;
      rx_old_r <= 4'h0;
    end else begin
      rx_s1_r  <= {rx_unlock_i, rx_rate_i, rx_preemph_i};
      rx_s2_r  <= rx_s1_r;
      rx_old_r <= rx_s2_r;
    end
  end

  always_comb begin
    spd_stat = '0;
    spd_stat[ST_PRE] = rx_s2_r[0];
    spd_stat[ST_RATE_LO +: 2] = rx_s2_r[2:1];
    spd_stat[ST_UNLOCK] = rx_s2_r[3];
  end

  ////////////////////////////////////////////////////////////
  // Control registers

  always_ff @(posedge clk_i) begin
    if (rst_i || soft_rst) begin
      pd1_r <= PD1_RST;
    end else if (wr_fire && idx == IDX_PD1) begin
      pd1_r <= merge_w(pd1_r, wb_dat_i, wb_sel_i) & PD1_MASK;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || soft_rst) begin
      pd2_r <= PD2_RST;
    end else if (wr_fire && idx == IDX_PD2) begin
      pd2_r <= merge_w(pd2_r, wb_dat_i, wb_sel_i) & PD2_MASK;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || soft_rst) begin
      rb_r <= RB_RST;
    end else if (wr_fire && idx == IDX_RB) begin
      rb_r <= merge_w(rb_r, wb_dat_i, wb_sel_i) & RB_MASK;
    end
  end

  ////////////////////////////////////////////////////////////
  // Power outputs

  assign outputs_mute_o = pd1_r[PD1_CHIP];
  assign adc_off_o = pd1_r[PD1_ADC] | pd1_r[PD1_CHIP];
  assign dac_off_o = pd1_r[PD1_DAC_LO +: 4]
                   | {4{pd1_r[PD1_ALL]}}
                   | {4{pd1_r[PD1_CHIP]}};
  assign oscillator_off_o = pd2_r[PD2_OSC];
  assign pll_a_off_o = pd2_r[PD2_PLLA];
  assign pll_b_off_o = pd2_r[PD2_PLLB];
  assign clock_recovery_off_o = pd2_r[PD2_CREC] | pd1_r[PD1_CHIP];
  assign spdif_transmitter_off_o = pd2_r[PD2_TX] | pd1_r[PD1_CHIP];
  assign spdif_receiver_off_o = pd2_r[PD2_RX] | pd1_r[PD1_CHIP];

  ////////////////////////////////////////////////////////////
  // Read-back path

  assign rb_sel_v = rb_mux(rb_r[RB_SEL_LO +: 3], error_status_i,
                           chan_status_i, spd_stat);

  // One snapshot follows each write of the read-back register that sets the enable bit
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rb_load_r <= 1'b0;
    end else begin
      rb_load_r <= wr_fire && (idx == IDX_RB);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || soft_rst) begin
      readback_data_o <= '0;
    end else if (!rb_r[RB_EN]) begin
      readback_data_o <= '0;
    end else if (rb_r[RB_CONT] || rb_load_r) begin
      readback_data_o <= rb_sel_v;
    end
  end

  assign readback_valid_o      = rb_r[RB_EN];
  assign readback_continuous_o = rb_r[RB_EN] & rb_r[RB_CONT];

  ////////////////////////////////////////////////////////////
  // Interrupts

  assign ev[EV_LOST] = rx_s2_r[3] && !rx_old_r[3];
  assign ev[EV_GAIN] = !rx_s2_r[3] && rx_old_r[3];
  assign ev[EV_RATE] = rx_s2_r[2:1] != rx_old_r[2:1];
  assign clr_v = (wr_fire && idx == IDX_INT_CLR)
               ? merge_w('0, wb_dat_i, wb_sel_i) : '0;

  // New events win over a clear in the same cycle
  assign int_st_nxt = (int_st_r & ~clr_v[INT_W-1:0]) | ev;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      int_st_r <= '0;
    end else begin
      int_st_r <= int_st_nxt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      int_en_r <= INT_EN_RST;
    end else if (wr_fire && idx == IDX_INT_EN) begin
      int_en_r <= wb_dat_i[INT_W-1:0];
    end
  end

  assign irq_o = |(int_st_r & int_en_r);

  ////////////////////////////////////////////////////////////
  // Read data

  always_comb begin
    rd_v = '0;
    case (idx)
      IDX_SPD_STAT: rd_v = spd_stat;
      IDX_PD1:      rd_v = pd1_r;
      IDX_PD2:      rd_v = pd2_r;
      IDX_RB:       rd_v = rb_r;
      IDX_INT_STAT: rd_v[INT_W-1:0] = int_st_r;
      IDX_INT_EN:   rd_v[INT_W-1:0] = int_en_r;
      default:      rd_v = '0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0;
    end else if (rd_take) begin
      wb_dat_o <= {23'h0, rd_v};
    end
  end

  ////////////////////////////////////////////////////////////
  // Checks

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      up_r <= 2'h0;
    end else if (up_r != 2'h3) begin
      up_r <= up_r + 2'h1;
    end
  end

  chk_preemph_sync: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (up_r == 2'h3) |-> spd_stat[ST_PRE] == $past(rx_preemph_i, 2))
    else $error("pre-emphasis flag not tracking input");

  chk_rate_sync: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (up_r == 2'h3) |-> spd_stat[ST_RATE_LO +: 2] == $past(rx_rate_i, 2))
    else $error("rate code not tracking input");

  chk_unlock_sync: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (up_r == 2'h3) |-> spd_stat[ST_UNLOCK] == $past(rx_unlock_i, 2))
    else $error("unlock flag not tracking input");

  chk_chip_mute: assert property (
    @(posedge clk_i) disable iff (rst_i)
    pd1_r[PD1_CHIP] |-> outputs_mute_o && adc_off_o && (&dac_off_o)
      && spdif_transmitter_off_o && spdif_receiver_off_o)
    else $error("power save left a block running");

  chk_adc_default: assert property (
    @(posedge clk_i) disable iff (rst_i)
    $fell(rst_i) |-> adc_off_o && (dac_off_o == 4'hf))
    else $error("ADC or DACs not off after reset");

  chk_dac_write: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (wr_fire && idx == IDX_PD1 && wb_sel_i == 4'hf) |=>
      dac_off_o == ($past(wb_dat_i[5:2]) | {4{$past(wb_dat_i[6])}}
                    | {4{$past(wb_dat_i[0])}}))
    else $error("DAC gates do not follow write");

  chk_every_dac: assert property (
    @(posedge clk_i) disable iff (rst_i)
    pd1_r[PD1_ALL] |-> dac_off_o == 4'hf)
    else $error("override left a DAC on");

  chk_osc_default: assert property (
    @(posedge clk_i) disable iff (rst_i)
    $fell(rst_i) |-> !oscillator_off_o)
    else $error("oscillator off after reset");

  chk_pll_default: assert property (
    @(posedge clk_i) disable iff (rst_i)
    $fell(rst_i) |-> pll_a_off_o && pll_b_off_o)
    else $error("PLL on after reset");

  chk_spdif_default: assert property (
    @(posedge clk_i) disable iff (rst_i)
    $fell(rst_i) |-> clock_recovery_off_o && spdif_transmitter_off_o
      && spdif_receiver_off_o)
    else $error("S/PDIF section on after reset");

  chk_rb_cont: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (rb_r[RB_EN] && rb_r[RB_CONT] && !soft_rst) |=>
      readback_data_o == $past(rb_sel_v))
    else $error("continuous read-back not refreshing");

  chk_rb_select: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (rb_load_r && rb_r[RB_EN] && !soft_rst) |=>
      readback_data_o == $past(rb_sel_v))
    else $error("read-back snapshot wrong");

  chk_rb_off: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !rb_r[RB_EN] |=> readback_data_o == 9'h000)
    else $error("read-back active while disabled");

  chk_soft_reset: assert property (
    @(posedge clk_i) disable iff (rst_i)
    soft_rst |=> pd1_r == PD1_RST && pd2_r == PD2_RST && rb_r == RB_RST)
    else $error("reset register write did not restore defaults");

  chk_status_ro: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (rd_take && idx == IDX_SPD_STAT) |=> wb_dat_o[8:0] == $past(spd_stat))
    else $error("status read does not show live state");

endmodule

// ==== sim/cps_host.sv ====
`timescale 1ns/1ps
module cps_host (
  // System
  input  wire logic        clk_i,
  // Wishbone master
  output logic             wb_cyc_o,
  output logic             wb_stb_o,
  output logic             wb_we_o,
  output logic [7:0]       wb_adr_o,
  output logic [3:0]       wb_sel_o,
  output logic [31:0]      wb_dat_o,
  input  wire logic        wb_ack_i,
  input  wire logic [31:0] wb_dat_i
);
  initial begin
    wb_cyc_o = 1'b0;
    wb_stb_o = 1'b0;
    wb_we_o  = 1'b0;
    wb_adr_o = 8'h00;
    wb_sel_o = 4'h0;
    wb_dat_o = 32'h0;
  end
  // Released address and data lines carry inverted values so stale data cannot pass
  task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                      output logic [31:0] rd);
    @(posedge clk_i);
    wb_cyc_o <= 1'b1;
    wb_stb_o <= 1'b1;
    wb_we_o  <= we;
    wb_adr_o <= adr;
    wb_sel_o <= 4'hf;
    wb_dat_o <= dat;
    do @(posedge clk_i); while (wb_ack_i !== 1'b1);
    rd = wb_dat_i;
    wb_cyc_o <= 1'b0;
    wb_stb_o <= 1'b0;
    wb_we_o  <= 1'b0;
    wb_adr_o <= ~adr;
    wb_sel_o <= 4'h0;
    wb_dat_o <= ~dat;
  endtask
endmodule

// ==== sim/cps_regs_tb_top.sv ====
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin miscompares++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end
module cps_regs_tb_top;
  import cps_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rdat;
  logic        rx_preemph_i = 1'b0;
  logic [1:0]  rx_rate_i = 2'h0;
  logic        rx_unlock_i = 1'b1;
  cps_reg_type error_status_i = 9'h000;
  logic [44:0] chan_status_i = 45'h0;
  logic        outputs_mute_o, adc_off_o, oscillator_off_o, pll_a_off_o, pll_b_off_o;
  logic        clock_recovery_off_o, spdif_transmitter_off_o, spdif_receiver_off_o;
  logic [3:0]  dac_off_o;
  cps_reg_type readback_data_o, spd_exp;
  logic        readback_valid_o, readback_continuous_o, irq_o;
  int          miscompares = 0;
  int          samples_checked = 0;
  always #5 clk_i = ~clk_i;
  cps_regs cps_regs_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .rx_preemph_i(rx_preemph_i), .rx_rate_i(rx_rate_i), .rx_unlock_i(rx_unlock_i),
    .error_status_i(error_status_i), .chan_status_i(chan_status_i),
    .outputs_mute_o(outputs_mute_o), .adc_off_o(adc_off_o), .dac_off_o(dac_off_o),
    .oscillator_off_o(oscillator_off_o), .pll_a_off_o(pll_a_off_o),
    .pll_b_off_o(pll_b_off_o), .clock_recovery_off_o(clock_recovery_off_o),
    .spdif_transmitter_off_o(spdif_transmitter_off_o),
    .spdif_receiver_off_o(spdif_receiver_off_o), .readback_data_o(readback_data_o),
    .readback_valid_o(readback_valid_o), .readback_continuous_o(readback_continuous_o),
    .irq_o(irq_o));
  cps_host cps_host_inst (.clk_i(clk_i), .wb_cyc_o(wb_cyc_i), .wb_stb_o(wb_stb_i),
    .wb_we_o(wb_we_i), .wb_adr_o(wb_adr_i), .wb_sel_o(wb_sel_i), .wb_dat_o(wb_dat_i),
    .wb_ack_i(wb_ack_o), .wb_dat_i(wb_dat_o));
  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [11:0] pdv();
    return {outputs_mute_o, adc_off_o, dac_off_o, spdif_receiver_off_o,
            spdif_transmitter_off_o, clock_recovery_off_o, pll_b_off_o, pll_a_off_o,
            oscillator_off_o};
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic wr(input logic [5:0] idx, input logic [31:0] d);
    cps_host_inst.xfer(1'b1, {idx, 2'b00}, d, rdat);
    @(negedge clk_i);
  endtask
  task automatic rd(input logic [5:0] idx);
    cps_host_inst.xfer(1'b0, {idx, 2'b00}, 32'h0, rdat);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_defaults();
    `CHK("power outs", 12'h7fe, pdv())
    rd(IDX_PD1);
    `CHK("pd1", {23'h0, PD1_RST}, rdat)
    rd(IDX_PD2);
    `CHK("pd2", {23'h0, PD2_RST}, rdat)
    rd(IDX_RB);
    `CHK("rb", {23'h0, RB_RST}, rdat)
    `CHK("rb valid", 1'b0, readback_valid_o)
    $display("test defaults done");
  endtask
  task automatic t_power();
    wr(IDX_PD2, 32'h0);
    wr(IDX_PD1, 32'h00c);
    `CHK("dac single", 12'h0c0, pdv())
    wr(IDX_PD1, 32'h040);
    `CHK("dac all", 12'h3c0, pdv())
    wr(IDX_PD1, 32'h001);
    `CHK("chip save", 12'hff8, pdv())
    wr(IDX_PD1, 32'h000);
    for (int i = 0; i < 6; i++) begin
      wr(IDX_PD2, 32'h1 << i);
      `CHK("pd2 bit", 12'(1 << i), pdv())
    end
    $display("test power done");
  endtask
  task automatic t_status();
    for (int r = 0; r < 4; r++) begin
      @(posedge clk_i);
      rx_rate_i <= 2'(r);
      rx_preemph_i <= r[0];
      rx_unlock_i <= ~r[0];
      spd_exp = {2'b0, ~r[0], 2'(r), r[0], 3'b0};
      cyc(4);
      rd(IDX_SPD_STAT);
      `CHK("status", {23'h0, spd_exp}, rdat)
    end
    wr(IDX_SPD_STAT, 32'h1ff);
    rd(IDX_SPD_STAT);
    `CHK("status ro", {23'h0, spd_exp}, rdat)
    $display("test status done");
  endtask
  task automatic t_readback();
    cps_reg_type src;
    error_status_i <= 9'h1a5;
    chan_status_i <= {9'h155, 9'h144, 9'h133, 9'h122, 9'h111};
    for (int s = 0; s < 8; s++) begin
      wr(IDX_RB, 32'h010 | s);
      cyc(2);
      // Code 7 selects nothing and must read back zero
      src = (s == 0) ? 9'h1a5 : (s == 6) ? spd_exp : (s == 7) ? 9'h000
          : 9'(9'h100 + 9'h011 * s);
      `CHK("rb data", src, readback_data_o)
      `CHK("rb valid", 1'b1, readback_valid_o)
    end
    wr(IDX_RB, 32'h019);
    @(posedge clk_i);
    chan_status_i[8:0] <= 9'h0aa;
    cyc(3);
    `CHK("rb cont", 9'h0aa, readback_data_o)
    `CHK("rb cont out", 1'b1, readback_continuous_o)
    wr(IDX_RB, 32'h008);
    cyc(2);
    `CHK("rb off", 11'h0, {readback_valid_o, readback_continuous_o, readback_data_o})
    $display("test readback done");
  endtask
  task automatic t_softreset();
    wr(IDX_PD1, 32'h0);
    wr(IDX_PD2, 32'h0);
    wr(IDX_RB, 32'h013);
    wr(IDX_RST, 32'h0);
    cyc(2);
    `CHK("soft outs", 12'h7fe, pdv())
    rd(IDX_PD1);
    `CHK("soft pd1", {23'h0, PD1_RST}, rdat)
    rd(IDX_RB);
    `CHK("soft rb", 32'h0, rdat)
    `CHK("soft rb data", 9'h0, readback_data_o)
    $display("test softreset done");
  endtask
  task automatic t_irq();
    // Status scenario raised lock lost, lock gained and rate change
    rd(IDX_INT_STAT);
    `CHK("int events", 32'h7, rdat)
    wr(IDX_INT_CLR, 32'h7);
    wr(IDX_INT_EN, 32'h1);
    @(posedge clk_i);
    rx_unlock_i <= 1'b1;
    cyc(5);
    `CHK("irq lost", 1'b1, irq_o)
    rd(IDX_INT_STAT);
    `CHK("int stat", 32'h1, rdat)
    wr(IDX_INT_CLR, 32'h1);
    `CHK("irq clr", 1'b0, irq_o)
    @(posedge clk_i);
    rx_unlock_i <= 1'b0;
    cyc(5);
    `CHK("irq masked", 1'b0, irq_o)
    wr(IDX_INT_EN, 32'h2);
    `CHK("irq gain", 1'b1, irq_o)
    rd(6'h00);
    `CHK("unmapped", 32'h0, rdat)
    $display("test irq done");
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    t_defaults();
    t_power();
    t_status();
    t_readback();
    t_softreset();
    t_irq();
    final_report();
  end
  initial begin
    repeat (5000) @(posedge clk_i);
    miscompares++;
    final_report();
  end
endmodule
